/* File: apso_consts.svh */
// Offsets, field positions, reset values and timing figures of the
// converter power-state and output-port block.
// Assumes a 100 MHz block clock and 32-bit register data.
`ifndef APSO_CONSTS_SVH
`define APSO_CONSTS_SVH

`define APSO_DATA_W 14
`define APSO_LVDS_BITS 11
`define APSO_LVDS_PAIRS 6

`define APSO_REG_CONFIG 8'h00
`define APSO_REG_DRIVE 8'h04
`define APSO_REG_STATUS 8'h08

`define APSO_CFG_MODE_LSB 0
`define APSO_CFG_SERIAL_BIT 3
`define APSO_CFG_LVDS_BIT 4
`define APSO_CFG_IFSEL_BIT 5
`define APSO_DRV_DATA_LSB 0
`define APSO_DRV_CLK_LSB 2

`define APSO_CONFIG_RST 32'h0000_0000
`define APSO_DRIVE_RST 32'h0000_0000

`define APSO_CLK_PERIOD_NS 10
`define APSO_FAST_WAKE_NS 100
`define APSO_SLOW_WAKE_NS 15000
`define APSO_STOP_PERIOD_NS 1000

`endif

/* File: apso_pkg.sv */
// Types shared by the converter power-state and output-port block.
// Assumes apso_consts.svh is on the include path.
`include "apso_consts.svh"

package apso_pkg;

	typedef enum logic [2:0]
	{
		MODE_NORMAL = 3'h0,
		MODE_OFF_A = 3'h1,
		MODE_OFF_B = 3'h2,
		MODE_OFF_AB = 3'h3,
		MODE_GPD = 3'h4,
		MODE_STBY_A = 3'h5,
		MODE_STBY_B = 3'h6,
		MODE_MUX = 3'h7
	} apso_mode_t;

	typedef enum logic [2:0]
	{
		ST_RUN = 3'h1,
		ST_DOWN = 3'h2,
		ST_WAKE = 3'h4
	} apso_state_t;

	typedef struct packed
	{
		logic ref_on;
		logic conv_a_on;
		logic conv_b_on;
	} apso_pwr_t;

	typedef struct packed
	{
		logic [`APSO_DATA_W-1:0] a;
		logic [`APSO_DATA_W-1:0] b;
	} apso_pair_t;

endpackage

/* File: apso_sync.sv */
// Two-flop synchroniser for a group of unrelated levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module apso_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_q <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			o_sync <= sync_d;
		end
	end

endmodule

`default_nettype wire

/* File: apso_core.sv */
// Power-state control and sample output port of a dual 14-bit converter.
// Assumes samples arrive on the block clock; pins and sample clock do not.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "apso_consts.svh"

module apso_core #(
	parameter int unsigned FAST_WAKE_CYC =
		(`APSO_FAST_WAKE_NS + `APSO_CLK_PERIOD_NS - 1) / `APSO_CLK_PERIOD_NS,
	parameter int unsigned SLOW_WAKE_CYC =
		(`APSO_SLOW_WAKE_NS + `APSO_CLK_PERIOD_NS - 1) / `APSO_CLK_PERIOD_NS,
	parameter int unsigned STOP_CYC =
		`APSO_STOP_PERIOD_NS / `APSO_CLK_PERIOD_NS
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_sample_clock,
	input wire logic i_mode_pin_msb,
	input wire logic i_mode_pin_mid,
	input wire logic i_mode_pin_lsb,
	input wire logic i_interface_select_pin,
	input wire apso_pkg::apso_pair_t i_sample,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [`APSO_DATA_W-1:0] o_bus_a_data,
	output logic [`APSO_DATA_W-1:0] o_bus_b_data,
	output logic o_bus_a_oe_b,
	output logic o_bus_b_oe_b,
	output logic o_sample_out_clock,
	output logic o_clock_oe_b,
	output logic o_data_valid,
	output logic o_low_power,
	output apso_pkg::apso_pwr_t o_power,
	output logic [1:0] o_data_drive_level,
	output logic [1:0] o_clock_drive_level
);
	import apso_pkg::*;

	// Even half of a pair slot carries bit 2k, odd half bit 2k+1 below bit 11, else zero
	function automatic logic [`APSO_LVDS_PAIRS-1:0] lvds_half(
		input logic [`APSO_DATA_W-1:0] d,
		input logic odd
	);
		logic [`APSO_LVDS_PAIRS-1:0] r;
		r = '0;
		for (int k = 0; k < `APSO_LVDS_PAIRS; k++)
		begin
			if (!odd)
				r[k] = d[2*k];
			else if (2*k + 1 < `APSO_LVDS_BITS)
				r[k] = d[2*k+1];
		end
		return r;
	endfunction

	logic [4:0] sync_s;
	logic sclk_s;
	logic [2:0] pins_s;
	logic ifsel_s;

	apso_sync #(
		.W(5)
	) u_sync (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_async({i_sample_clock, i_mode_pin_msb, i_mode_pin_mid,
			i_mode_pin_lsb, i_interface_select_pin}),
		.o_sync(sync_s)
	);

	assign sclk_s = sync_s[4];
	assign pins_s = sync_s[3:1];
	assign ifsel_s = sync_s[0];

	// Register file
	logic [2:0] cfg_mode_q, cfg_mode_d;
	logic cfg_serial_q, cfg_serial_d;
	logic cfg_lvds_q, cfg_lvds_d;
	logic cfg_ifsel_q, cfg_ifsel_d;
	logic [1:0] drv_data_q, drv_data_d;
	logic [1:0] drv_clk_q, drv_clk_d;
	logic [31:0] rdata_d;

	apso_mode_t eff_mode;
	logic lvds_eff;
	logic mux_eff;
	logic down_now;
	logic rise;
	logic fall;

	logic sclk_q, sclk_d;
	logic [15:0] gap_q, gap_d;
	logic stopped_q, stopped_d;
	apso_state_t state_q, state_d;
	logic [15:0] wake_cnt_q, wake_cnt_d;
	logic slow_q, slow_d;
	logic valid_d;

	always_comb
	begin
		cfg_mode_d = cfg_mode_q;
		cfg_serial_d = cfg_serial_q;
		cfg_lvds_d = cfg_lvds_q;
		cfg_ifsel_d = cfg_ifsel_q;
		drv_data_d = drv_data_q;
		drv_clk_d = drv_clk_q;
		rdata_d = '0;
		if (i_wr)
		begin
			case (i_addr)
				`APSO_REG_CONFIG:
				begin
					cfg_mode_d = i_wdata[`APSO_CFG_MODE_LSB +: 3];
					cfg_serial_d = i_wdata[`APSO_CFG_SERIAL_BIT];
					cfg_lvds_d = i_wdata[`APSO_CFG_LVDS_BIT];
					cfg_ifsel_d = i_wdata[`APSO_CFG_IFSEL_BIT];
				end
				`APSO_REG_DRIVE:
				begin
					drv_data_d = i_wdata[`APSO_DRV_DATA_LSB +: 2];
					drv_clk_d = i_wdata[`APSO_DRV_CLK_LSB +: 2];
				end
				default:
				begin
				end
			endcase
		end
		if (i_rd)
		begin
			case (i_addr)
				`APSO_REG_CONFIG:
					rdata_d = {26'h0, cfg_ifsel_q, cfg_lvds_q, cfg_serial_q,
						cfg_mode_q};
				`APSO_REG_DRIVE:
					rdata_d = {28'h0, drv_clk_q, drv_data_q};
				`APSO_REG_STATUS:
					rdata_d = {23'h0, o_power, o_data_valid, stopped_q,
						lvds_eff, eff_mode};
				default:
					rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cfg_mode_q <= 3'(`APSO_CONFIG_RST >> `APSO_CFG_MODE_LSB);
			cfg_serial_q <= 1'(`APSO_CONFIG_RST >> `APSO_CFG_SERIAL_BIT);
			cfg_lvds_q <= 1'(`APSO_CONFIG_RST >> `APSO_CFG_LVDS_BIT);
			cfg_ifsel_q <= 1'(`APSO_CONFIG_RST >> `APSO_CFG_IFSEL_BIT);
			drv_data_q <= 2'(`APSO_DRIVE_RST >> `APSO_DRV_DATA_LSB);
			drv_clk_q <= 2'(`APSO_DRIVE_RST >> `APSO_DRV_CLK_LSB);
			o_rdata <= '0;
		end
		else
		begin
			cfg_mode_q <= cfg_mode_d;
			cfg_serial_q <= cfg_serial_d;
			cfg_lvds_q <= cfg_lvds_d;
			cfg_ifsel_q <= cfg_ifsel_d;
			drv_data_q <= drv_data_d;
			drv_clk_q <= drv_clk_d;
			o_rdata <= rdata_d;
		end
	end

	// Source of the power state and of the interface type
	always_comb
	begin
		eff_mode = cfg_serial_q ? apso_mode_t'(cfg_mode_q) :
			apso_mode_t'(pins_s);
		lvds_eff = cfg_ifsel_q ? cfg_lvds_q : ifsel_s;
		// Mux in LVDS is not offered, so it falls back to normal
		mux_eff = (eff_mode == MODE_MUX) && !lvds_eff;
		down_now = stopped_q || !(eff_mode == MODE_NORMAL ||
			eff_mode == MODE_MUX);
		rise = sclk_s && !sclk_q;
		fall = !sclk_s && sclk_q;
	end

	// Clock-stop watch and wake sequencing
	always_comb
	begin
		sclk_d = sclk_s;
		gap_d = gap_q;
		stopped_d = stopped_q;
		state_d = state_q;
		wake_cnt_d = wake_cnt_q;
		slow_d = slow_q;
		if (rise)
		begin
			gap_d = '0;
			stopped_d = 1'b0;
		end
		else if (gap_q >= 16'(STOP_CYC))
			stopped_d = 1'b1;
		else
			gap_d = gap_q + 16'h0001;
		case (state_q)
			ST_RUN:
			begin
				slow_d = 1'b0;
				if (down_now)
				begin
					state_d = ST_DOWN;
					slow_d = (eff_mode == MODE_GPD) || stopped_q;
				end
			end
			ST_DOWN:
			begin
				slow_d = slow_q || (eff_mode == MODE_GPD) || stopped_q;
				if (!down_now)
				begin
					state_d = ST_WAKE;
					wake_cnt_d = slow_q ? 16'(SLOW_WAKE_CYC - 1) :
						16'(FAST_WAKE_CYC - 1);
				end
			end
			ST_WAKE:
			begin
				if (down_now)
				begin
					state_d = ST_DOWN;
				end
				else if (wake_cnt_q == 16'h0000)
					state_d = ST_RUN;
				else
					wake_cnt_d = wake_cnt_q - 16'h0001;
			end
			default:
				state_d = ST_DOWN;
		endcase
		valid_d = (state_d == ST_RUN);
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sclk_q <= 1'b0;
			gap_q <= '0;
			stopped_q <= 1'b0;
			state_q <= ST_RUN;
			wake_cnt_q <= '0;
			slow_q <= 1'b0;
			o_data_valid <= 1'b0;
		end
		else
		begin
			sclk_q <= sclk_d;
			gap_q <= gap_d;
			stopped_q <= stopped_d;
			state_q <= state_d;
			wake_cnt_q <= wake_cnt_d;
			slow_q <= slow_d;
			o_data_valid <= valid_d;
		end
	end

	// Output port
	apso_pair_t cap_q, cap_d;
	logic [`APSO_DATA_W-1:0] bus_a_d, bus_b_d;
	logic oe_a_d, oe_b_d, oe_clk_d;
	apso_pwr_t pwr_d;
	logic gpd;

	always_comb
	begin
		gpd = (eff_mode == MODE_GPD);
		cap_d = cap_q;
		bus_a_d = o_bus_a_data;
		bus_b_d = o_bus_b_data;
		oe_a_d = gpd || eff_mode == MODE_OFF_A ||
			eff_mode == MODE_OFF_AB || mux_eff;
		oe_b_d = gpd || eff_mode == MODE_OFF_B ||
			eff_mode == MODE_OFF_AB;
		oe_clk_d = gpd;
		pwr_d.ref_on = !gpd;
		pwr_d.conv_a_on = !(gpd || stopped_q ||
			eff_mode == MODE_STBY_A);
		pwr_d.conv_b_on = !(gpd || stopped_q || eff_mode == MODE_STBY_B);
		if (lvds_eff)
		begin
			if (rise)
			begin
				cap_d = i_sample;
				bus_a_d = {8'h00, lvds_half(i_sample.a, 1'b0)};
				bus_b_d = {8'h00, lvds_half(i_sample.b, 1'b0)};
			end
			else if (fall)
			begin
				bus_a_d = {8'h00, lvds_half(cap_q.a, 1'b1)};
				bus_b_d = {8'h00, lvds_half(cap_q.b, 1'b1)};
			end
		end
		else if (mux_eff)
		begin
			// Doubles the bus rate, hence only for slow sample clocks
			if (rise)
			begin
				cap_d = i_sample;
				bus_b_d = i_sample.a;
			end
			else if (fall)
				bus_b_d = cap_q.b;
		end
		else if (rise)
		begin
			cap_d = i_sample;
			bus_a_d = i_sample.a;
			bus_b_d = i_sample.b;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cap_q <= '0;
			o_bus_a_data <= '0;
			o_bus_b_data <= '0;
			o_bus_a_oe_b <= 1'b1;
			o_bus_b_oe_b <= 1'b1;
			o_clock_oe_b <= 1'b1;
			o_sample_out_clock <= 1'b0;
			o_power <= '0;
			o_low_power <= 1'b0;
			o_data_drive_level <= '0;
			o_clock_drive_level <= '0;
		end
		else
		begin
			cap_q <= cap_d;
			o_bus_a_data <= bus_a_d;
			o_bus_b_data <= bus_b_d;
			o_bus_a_oe_b <= oe_a_d;
			o_bus_b_oe_b <= oe_b_d;
			o_clock_oe_b <= oe_clk_d;
			o_sample_out_clock <= sclk_s;
			o_power <= pwr_d;
			o_low_power <= stopped_q;
			o_data_drive_level <= drv_data_q;
			o_clock_drive_level <= drv_clk_q;
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	a_gpd_all_hiz: assert property (gpd |=> o_bus_a_oe_b &&
		o_bus_b_oe_b && o_clock_oe_b && !o_power.ref_on &&
		!o_power.conv_a_on) else $error("global down left a driver on");
	a_off_a_hiz: assert property ((eff_mode == MODE_OFF_A &&
		!stopped_q) |=> o_bus_a_oe_b && !o_bus_b_oe_b && o_power.conv_a_on)
		else $error("channel A disable wrong");
	a_stby_ref_on: assert property ((eff_mode == MODE_STBY_A &&
		!stopped_q) |=> !o_power.conv_a_on && o_power.conv_b_on &&
		o_power.ref_on) else $error("standby power wrong");
	a_mux_a_hiz: assert property (mux_eff |=>
		o_bus_a_oe_b && !o_bus_b_oe_b) else $error("mux bus A driven");
	a_mux_interleave: assert property ((mux_eff && fall) |=>
		o_bus_b_data == $past(cap_q.b)) else $error("mux B sample missing");
	a_cmos_update: assert property ((!lvds_eff && !mux_eff && rise) |=>
		o_bus_a_data == $past(i_sample.a) &&
		o_bus_b_data == $past(i_sample.b)) else $error("CMOS not updated");
	a_lvds_even: assert property ((lvds_eff && rise) |=>
		o_sample_out_clock && o_bus_a_data == {8'h00,
		lvds_half($past(i_sample.a), 1'b0)}) else $error("even bits wrong");
	a_lvds_odd: assert property ((lvds_eff && fall) |=>
		!o_sample_out_clock && o_bus_b_data == {8'h00,
		lvds_half($past(cap_q.b), 1'b1)}) else $error("odd bits wrong");
	a_stop_low_power: assert property ((gap_q >= 16'(STOP_CYC) &&
		!rise) |=> ##1 o_low_power) else $error("clock stop missed");
	a_wake_hold: assert property ((state_q == ST_DOWN &&
		!down_now) |=> (!o_data_valid)[*8]) else $error("valid too early");
	a_fast_wake_end: assert property ((state_q == ST_DOWN &&
		!down_now && !slow_q) ##1 (!down_now)[*8] |-> ##[1:4] o_data_valid)
		else $error("fast wake too long");

	c_mux: cover property (mux_eff && fall);
	c_lvds: cover property (lvds_eff && fall);
	c_gpd_wake: cover property (state_q == ST_WAKE && slow_q);
	c_clock_stop: cover property ($rose(o_low_power));

endmodule

`default_nettype wire

/* File: apso_rx.sv */
// Receiving-side model of the sample port: takes bus B on both clock edges.
// Assumes data launch in the same step as the output clock edge.
`timescale 1ns/1ps
`default_nettype none

module apso_rx (
	input wire logic i_out_clock,
	input wire logic [13:0] i_bus,
	output logic [13:0] o_rise,
	output logic [13:0] o_fall
);
	// Small settle delay so the word launched with this edge is the one taken
	always @(posedge i_out_clock)
	begin
		#1 o_rise = i_bus;
	end

	always @(negedge i_out_clock)
	begin
		#1 o_fall = i_bus;
	end
endmodule

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for apso_core and the bus B receiver model.
// Assumes the package is compiled first; sample clock period 80 ns.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import apso_pkg::*;
	logic clk, rst_b, sclk, sclk_run, pm, pd, pl, ifp, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	apso_pair_t smp;
	logic [13:0] bus_a, bus_b, rx_r, rx_f, er, ef;
	logic oe_a, oe_b, oclk, coe, valid, lowp;
	apso_pwr_t pwr;
	logic [1:0] dlev, clev;
	int n_fail, num_checks, seed, n;

	// Short slow wake keeps the run brief
	apso_core #(.SLOW_WAKE_CYC(20)) u_apso_core (
		.i_clock(clk), .i_rst_b(rst_b), .i_sample_clock(sclk),
		.i_mode_pin_msb(pm), .i_mode_pin_mid(pd), .i_mode_pin_lsb(pl),
		.i_interface_select_pin(ifp), .i_sample(smp), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_bus_a_data(bus_a), .o_bus_b_data(bus_b), .o_bus_a_oe_b(oe_a),
		.o_bus_b_oe_b(oe_b), .o_sample_out_clock(oclk), .o_clock_oe_b(coe),
		.o_data_valid(valid), .o_low_power(lowp), .o_power(pwr),
		.o_data_drive_level(dlev), .o_clock_drive_level(clev));

	apso_rx u_apso_rx (.i_out_clock(oclk), .i_bus(bus_b), .o_rise(rx_r),
		.o_fall(rx_f));

	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	// Link clock, off phase with the block clock; stands still when stopped
	initial
	begin
		sclk = 0;
		#3;
		forever #40 if (sclk_run) sclk = ~sclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask

	// {oe_a_b, oe_b_b, ref, conv_a, conv_b, valid} per power code
	function automatic logic [5:0] exp_mode(input int m);
		return {m == 1 || m == 3 || m == 4 || m == 7,
			m == 2 || m == 3 || m == 4, m != 4, m != 4 && m != 5,
			m != 4 && m != 6, m == 0 || m == 7};
	endfunction

	task automatic set_mode(input int p, input int m);
		if (p)
		begin
			wr_reg(8'h00, 32'h0);
			{pm, pd, pl} <= 3'(m);
		end
		else
			wr_reg(8'h00, 32'h8 | m);
		repeat (40) @(posedge clk);
		#1;
	endtask

	// New random sample, then wait until a full capture of it has left
	task automatic step();
		@(posedge clk);
		smp <= {14'($random(seed)), 14'($random(seed))};
		@(posedge oclk);
		@(posedge oclk);
		@(negedge oclk);
		#2;
	endtask

	task automatic wake(input logic [31:0] from, input int lo, input int hi);
		wr_reg(8'h00, from);
		repeat (40) @(posedge clk);
		wr_reg(8'h00, 32'h8);
		n = 0;
		while (valid !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask

	initial
	begin
		#300000;
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		seed = 32313;
		{rst_b, pm, pd, pl, ifp, wr, rd} = 0;
		addr = 0;
		wdata = 0;
		smp = 0;
		sclk_run = 1;
		repeat (10) @(posedge clk);
		rst_b <= 1;
		rd_reg(8'h04, rv);
		chk(rv, 32'h0);
		wr_reg(8'h04, 32'h6);
		@(posedge clk);
		#1 chk({dlev, clev}, 4'h9);
		wr_reg(8'h04, 32'hf);
		@(posedge clk);
		#1 chk({dlev, clev}, 4'hf);
		rd_reg(8'h40, rv);
		chk(rv, 32'h0);
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 8; m++)
			begin
				set_mode(p, m);
				chk({oe_a, oe_b, pwr, valid}, exp_mode(m));
				chk(coe, m == 4);
				rd_reg(8'h08, rv);
				chk(rv[2:0], m);
			end
		set_mode(0, 0);
		repeat (3)
		begin
			step();
			chk({bus_a, bus_b}, smp);
		end
		set_mode(0, 7);
		repeat (3)
		begin
			step();
			chk({rx_r, rx_f}, smp);
		end
		for (int i = 0; i < 2; i++)
		begin
			ifp <= !i;
			if (i)
			begin
				wr_reg(8'h00, 32'h38);
				repeat (40) @(posedge clk);
			end
			else
				set_mode(1, 0);
			step();
			er = 0;
			ef = 0;
			for (int k = 0; k < 6; k++)
			begin
				er[k] = smp.b[2 * k];
				ef[k] = (k < 5) ? smp.b[2 * k + 1] : 1'b0;
			end
			chk({rx_r, rx_f}, {er, ef});
		end
		ifp <= 0;
		wake(32'h9, 9, 14);
		wake(32'hc, 19, 24);
		@(negedge sclk);
		sclk_run = 0;
		repeat (150) @(posedge clk);
		#1 chk({lowp, valid, pwr}, 5'b10100);
		rd_reg(8'h08, rv);
		chk(rv[5:3], 3'b010);
		sclk_run = 1;
		n = 0;
		while (valid !== 1'b1 && n < 80)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk({lowp, valid}, 2'b01);
		report_and_stop();
	end
endmodule

`default_nettype wire
